// file: hw/wsw_pkg.sv
package wsw_pkg;

   // register indices on the plain register port
   localparam logic [3:0] REG_CTRL       = 4'h0;
   localparam logic [3:0] REG_CFG        = 4'h1;
   localparam logic [3:0] REG_CAUSE      = 4'h2;
   localparam logic [3:0] REG_IRQ_STATUS = 4'h3;
   localparam logic [3:0] REG_IRQ_CLEAR  = 4'h4;
   localparam logic [3:0] REG_IRQ_ENABLE = 4'h5;

   // field positions
   localparam int CTRL_SW_EN_BIT   = 0;
   localparam int CFG_EN_BIT       = 0;
   localparam int CFG_PS_LSB       = 1;
   localparam int CAUSE_PD_BIT     = 3;
   localparam int CAUSE_TO_BIT     = 4;
   localparam int IRQ_TIMEOUT_BIT  = 0;
   localparam int IRQ_WAKE_BIT     = 1;
   localparam int IRQ_SLEEP_BIT    = 2;
   localparam int IRQ_RESET_BIT    = 3;

   // reset values
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [3:0] IRQ_RESET    = 4'h0;
   localparam logic       FLAG_N_RESET = 1'b1;
   localparam logic [7:0] BYTE_ZERO    = 8'h00;

   // timing: the watchdog's own oscillator ticks once per period
   localparam int         CLK_PERIOD_NS = 8;
   localparam int         RC_PERIOD_NS  = 1000;
   localparam int         RC_CYC        = RC_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [7:0] RC_LAST       = 8'(RC_CYC - 1);
   localparam int         BASE_TICKS_DEFAULT = 18000;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } wsw_bus_req_type;

   typedef struct packed {
      logic psp_access;
      logic timer_one_interrupt;
      logic timer_one_async;
      logic timer_three_interrupt;
      logic timer_three_async;
      logic capture_interrupt;
      logic sync_serial_start_stop;
      logic sync_serial_slave;
      logic usart_interrupt;
      logic usart_sync_slave;
      logic adc_done;
      logic adc_rc_clock;
      logic eeprom_write_done;
      logic low_voltage_detect;
   } wsw_periph_type;

endpackage : wsw_pkg

// file: hw/wsw_watchdog_sleep_wake.sv
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps

// How it works
// (R1) watchdog counts ticks of its own oscillator, running through sleep
// (R2) timeout while running pulses the watchdog device reset
// (R3) timeout while asleep wakes the device instead of resetting it
// (R4) every timeout clears the timeout flag
// (R5) configuration enable forces the watchdog on regardless of software
// (R6) with configuration enable clear, software enable bit 0 switches it
// (R7) software enable resets to 0; upper seven control bits read zero
// (R8) clear or sleep instruction zeroes counter and postscaler count
// (R9) clear instruction leaves the postscaler selection untouched
// (R10) postscaler ratio comes from configuration bits 4 down to 1
// (R11) sleep clears watchdog, clears power-down flag and sets timeout (a timeout in the same cycle clears the timeout flag, power-down holds), stops driver
// (R12) ports hold their driven level and enable throughout sleep
// (R13) wake on master clear, timeout, edge interrupt, port change, peripheral
// (R14) only the listed peripheral conditions may wake the device
// (R15) base timeout period is a module parameter
module wsw_watchdog_sleep_wake
   import wsw_pkg::*;
#(
   parameter int BASE_TICKS = BASE_TICKS_DEFAULT
) (
   input  wire logic            sys_clk,
   input  wire logic            nrst,
   input  wire wsw_bus_req_type bus_req,
   output logic [7:0]           rdata_q,
   input  wire logic [7:0]      watchdog_config_byte,
   input  wire logic            master_clear_pin_n,
   input  wire logic            clear_watchdog_instr,
   input  wire logic            sleep_instr,
   input  wire logic            external_edge_interrupt,
   input  wire logic            port_b_change,
   input  wire wsw_periph_type  periph,
   input  wire logic [7:0]      port_drive,
   input  wire logic [7:0]      port_oe_n,
   output logic [7:0]           port_out_q,
   output logic [7:0]           port_oe_n_q,
   output logic                 watchdog_reset_q,
   output logic                 wake_q,
   output logic                 sleeping_q,
   output logic                 osc_driver_on_q,
   output logic                 irq_q
);

   localparam int RC_GAP = RC_CYC;

   function automatic logic [15:0] ps_last(input logic [3:0] sel);
      ps_last = (16'h0001 << sel) - 16'h0001;
   endfunction : ps_last

   // two-stage synchronisers for pins
   logic [7:0]  cfg_meta_q;
   logic [7:0]  cfg_q;
   logic        master_clear_pin_meta_q;
   logic        master_clear_pin_n_q;

   logic        sw_en_q;
   logic [7:0]  rc_div_q;
   logic [31:0] base_cnt_q;
   logic [15:0] ps_cnt_q;
   logic        to_n_q;
   logic        pd_n_q;
   logic [3:0]  irq_stat_q;
   logic [3:0]  irq_en_q;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_meta_q  <= BYTE_ZERO;
         cfg_q       <= BYTE_ZERO;
         master_clear_pin_meta_q <= 1'b1;
         master_clear_pin_n_q    <= 1'b1;
      end else begin
         cfg_meta_q  <= watchdog_config_byte;
         cfg_q       <= cfg_meta_q;
         master_clear_pin_meta_q <= master_clear_pin_n;
         master_clear_pin_n_q    <= master_clear_pin_meta_q;
      end
   end

   // decode
   wire        wr_ctrl    = bus_req.wr && (bus_req.addr == REG_CTRL);
   wire        wr_irq_clr = bus_req.wr && (bus_req.addr == REG_IRQ_CLEAR);
   wire        wr_irq_en  = bus_req.wr && (bus_req.addr == REG_IRQ_ENABLE);
   wire        cfg_en     = cfg_q[CFG_EN_BIT];
   wire [3:0]  ps_sel     = cfg_q[CFG_PS_LSB +: 4];                          // [R10]
   wire        wdt_run    = cfg_en || sw_en_q;                               // [R5] [R6]

   // free-running oscillator model: never gated by sleep
   wire        rc_tick    = (rc_div_q == RC_LAST);                           // [R1]
   wire        base_wrap  = wdt_run && rc_tick &&
                            (base_cnt_q == 32'(BASE_TICKS - 1));             // [R15]
   wire        timeout    = base_wrap && (ps_cnt_q == ps_last(ps_sel));      // [R10]
   wire        sleep_go   = sleep_instr && !sleeping_q;
   wire        wdt_clear  = clear_watchdog_instr || sleep_go || !wdt_run;    // [R8]

   // capture itself is suppressed while asleep, only its interrupt wakes
   wire        periph_wake = periph.psp_access ||
                             (periph.timer_one_interrupt && periph.timer_one_async) ||
                             (periph.timer_three_interrupt && periph.timer_three_async) ||
                             periph.capture_interrupt ||
                             periph.sync_serial_start_stop ||
                             periph.sync_serial_slave ||
                             (periph.usart_interrupt && periph.usart_sync_slave) ||
                             (periph.adc_done && periph.adc_rc_clock) ||
                             periph.eeprom_write_done ||
                             periph.low_voltage_detect;                      // [R14]
   wire        wake_ev    = sleeping_q && (!master_clear_pin_n_q || timeout ||
                            external_edge_interrupt || port_b_change ||
                            periph_wake);                                    // [R13]

   wire [3:0]  irq_events = {timeout && !sleeping_q, sleep_go, wake_ev, timeout};
   // set wins over a clear landing in the same cycle
   wire [3:0]  irq_stat_d = (irq_stat_q & ~(wr_irq_clr ? bus_req.wdata[3:0] : IRQ_RESET))
                            | irq_events;

   wire [7:0]  ctrl_rd    = {7'h00, sw_en_q};                                // [R7]
   wire [7:0]  cause_rd   = (8'(to_n_q) << CAUSE_TO_BIT) | (8'(pd_n_q) << CAUSE_PD_BIT);
   wire [7:0]  rd_mux     = (bus_req.addr == REG_CTRL)       ? ctrl_rd :
                            (bus_req.addr == REG_CFG)        ? cfg_q :
                            (bus_req.addr == REG_CAUSE)      ? cause_rd :
                            (bus_req.addr == REG_IRQ_STATUS) ? {4'h0, irq_stat_q} :
                            (bus_req.addr == REG_IRQ_ENABLE) ? {4'h0, irq_en_q} :
                            BYTE_ZERO;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sw_en_q  <= CTRL_RESET[CTRL_SW_EN_BIT];                             // [R7]
         irq_en_q <= IRQ_RESET;
         rdata_q  <= BYTE_ZERO;
      end else begin
         if (wr_ctrl) begin
            sw_en_q <= bus_req.wdata[CTRL_SW_EN_BIT];                        // [R6]
         end
         if (wr_irq_en) begin
            irq_en_q <= bus_req.wdata[3:0];
         end
         rdata_q <= bus_req.rd ? rd_mux : BYTE_ZERO;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rc_div_q <= BYTE_ZERO;
      end else begin
         rc_div_q <= rc_tick ? BYTE_ZERO : rc_div_q + 8'h01;                 // [R1]
      end
   end

   // postscaler selection lives in configuration, only its count is cleared
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         base_cnt_q <= 32'h0;
         ps_cnt_q   <= 16'h0;
      end else if (wdt_clear || timeout) begin
         base_cnt_q <= 32'h0;                                                // [R8]
         ps_cnt_q   <= 16'h0;                                                // [R9]
      end else if (base_wrap) begin
         base_cnt_q <= 32'h0;
         ps_cnt_q   <= ps_cnt_q + 16'h0001;                                  // [R10]
      end else if (rc_tick) begin
         base_cnt_q <= base_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         to_n_q <= FLAG_N_RESET;
         pd_n_q <= FLAG_N_RESET;
      end else if (timeout) begin
         to_n_q <= 1'b0;                                                     // [R4]
      end else if (sleep_go) begin
         to_n_q <= 1'b1;                                                     // [R11]
         pd_n_q <= 1'b0;                                                     // [R11]
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sleeping_q       <= 1'b0;
         osc_driver_on_q  <= 1'b1;
         wake_q           <= 1'b0;
         watchdog_reset_q <= 1'b0;
      end else begin
         sleeping_q       <= sleep_go || (sleeping_q && !wake_ev);
         osc_driver_on_q  <= !(sleep_go || (sleeping_q && !wake_ev));        // [R11]
         wake_q           <= wake_ev;                                        // [R3]
         watchdog_reset_q <= timeout && !sleeping_q;                         // [R2]
      end
   end

   // ports frozen from the sleep instruction until wake
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         port_out_q  <= BYTE_ZERO;
         port_oe_n_q <= 8'hff;
      end else if (!sleeping_q && !sleep_go) begin
         port_out_q  <= port_drive;                                          // [R12]
         port_oe_n_q <= port_oe_n;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_stat_q <= IRQ_RESET;
         irq_q      <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_q      <= |(irq_stat_d & irq_en_q);
      end
   end

   // cycles since the last clear or timeout; only the period check reads it
   logic [47:0] since_clr_q;
   wire  [47:0] period_ticks = 48'(BASE_TICKS) * (48'(ps_last(ps_sel)) + 48'h1);
   wire  [47:0] period_min   = (period_ticks - 48'h1) * 48'(RC_CYC);
   wire  [47:0] period_max   = period_ticks * 48'(RC_CYC);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         since_clr_q <= 48'h0;
      end else if (wdt_clear || timeout) begin
         since_clr_q <= 48'h0;
      end else begin
         since_clr_q <= since_clr_q + 48'h1;
      end
   end

   // checks
   sequence sleep_entered_s;
      sleeping_q && !pd_n_q && to_n_q && !osc_driver_on_q;
   endsequence

   sequence wake_done_s;
      wake_q && !watchdog_reset_q ##1 !sleeping_q && osc_driver_on_q;
   endsequence

   rc_runs_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1]
      rc_tick |-> ##RC_GAP rc_tick)
      else $error("watchdog oscillator tick lost");

   run_reset_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R2]
      (timeout && !sleeping_q) |=> watchdog_reset_q && !wake_q)
      else $error("timeout while running gave no reset");

   sleep_wake_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
      (timeout && sleeping_q) |=> wake_done_s)
      else $error("timeout in sleep did not wake cleanly");

   to_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
      timeout |=> !to_n_q)
      else $error("timeout flag not cleared on timeout");

   cfg_force_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R5]
      (cfg_en && rc_tick && !wdt_clear && !base_wrap) |=> base_cnt_q == $past(base_cnt_q) + 32'h1)
      else $error("forced watchdog stopped counting");

   sw_off_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R6]
      (!cfg_en && !sw_en_q) |=> base_cnt_q == 32'h0 && !watchdog_reset_q)
      else $error("disabled watchdog kept counting");

   ctrl_read_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R7]
      (bus_req.rd && bus_req.addr == REG_CTRL) |=> rdata_q == {7'h00, sw_en_q})
      else $error("control register read wrong");

   clear_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R8]
      (clear_watchdog_instr || sleep_go) |=> base_cnt_q == 32'h0 && ps_cnt_q == 16'h0)
      else $error("clear left watchdog count");

   ps_bound_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
      ps_cnt_q <= ps_last(ps_sel) || $changed(ps_sel))
      else $error("postscaler count beyond ratio");

   sleep_entry_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
      (sleep_go && !timeout) |=> sleep_entered_s)
      else $error("sleep entry state wrong");

   port_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
      (sleeping_q && $past(sleeping_q)) |-> $stable(port_out_q) && $stable(port_oe_n_q))
      else $error("port changed during sleep");

   master_clear_pin_wake_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R13]
      (sleeping_q && !master_clear_pin_n_q) |=> wake_q ##1 !sleeping_q)
      else $error("master clear did not wake");

   periph_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R14]
      (sleeping_q && !timeout && master_clear_pin_n_q && !external_edge_interrupt && !port_b_change &&
       !periph.psp_access && !periph.capture_interrupt && !periph.sync_serial_start_stop &&
       !periph.sync_serial_slave && !periph.eeprom_write_done && !periph.low_voltage_detect &&
       !periph.timer_one_async && !periph.timer_three_async && !periph.usart_sync_slave &&
       !periph.adc_rc_clock) |=> !wake_q)
      else $error("disallowed peripheral woke device");

   period_span_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10] [R15]
      timeout |-> (since_clr_q >= period_min) && (since_clr_q < period_max))
      else $error("timeout outside its period");

   osc_inverse_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
      osc_driver_on_q == !sleeping_q)
      else $error("oscillator driver out of step with sleep");

   wake_awake_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
      wake_q |-> !sleeping_q && osc_driver_on_q)
      else $error("wake pulse while still asleep");

   awake_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R13]
      !sleeping_q |=> !wake_q)
      else $error("wake pulse without sleep");

   reset_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R2]
      watchdog_reset_q |=> !watchdog_reset_q)
      else $error("watchdog reset longer than one cycle");

   sw_write_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R6]
      wr_ctrl |=> sw_en_q == $past(bus_req.wdata[CTRL_SW_EN_BIT]))
      else $error("software enable write lost");

   cause_read_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
      (bus_req.rd && bus_req.addr == REG_CAUSE) |=>
      rdata_q[CAUSE_TO_BIT] == $past(to_n_q) && rdata_q[CAUSE_PD_BIT] == $past(pd_n_q))
      else $error("cause register read wrong");

   pd_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
      !sleep_go |=> $stable(pd_n_q))
      else $error("power-down flag moved without sleep");

   to_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
      (!timeout && !sleep_go) |=> $stable(to_n_q))
      else $error("timeout flag moved without cause");

   sleep_timeout_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
      (sleep_go && timeout) |=> !to_n_q && sleeping_q)
      else $error("timeout during sleep entry mishandled");

   ps_step_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
      (base_wrap && !timeout && !wdt_clear) |=> ps_cnt_q == $past(ps_cnt_q) + 16'h0001)
      else $error("postscaler did not advance");

   rc_bound_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1]
      rc_div_q <= RC_LAST)
      else $error("oscillator divider out of range");

   port_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
      (!sleeping_q && !sleep_go) |=>
      port_out_q == $past(port_drive) && port_oe_n_q == $past(port_oe_n))
      else $error("ports not following core while awake");

   rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !bus_req.rd |=> rdata_q == BYTE_ZERO)
      else $error("read data not idle");

   irq_level_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ((irq_stat_q & irq_en_q) != IRQ_RESET && !wr_irq_clr && !wr_irq_en) |=> irq_q)
      else $error("interrupt low with enabled status set");

   irq_sticky_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (irq_events != IRQ_RESET) |=> (irq_stat_q & $past(irq_events)) == $past(irq_events))
      else $error("status event lost");

   irq_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wr_irq_clr && irq_events == IRQ_RESET) |=>
      (irq_stat_q & $past(bus_req.wdata[3:0])) == IRQ_RESET)
      else $error("status clear ignored");

   cfg_read_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
      (bus_req.rd && bus_req.addr == REG_CFG) |=> rdata_q == $past(cfg_q))
      else $error("configuration read wrong");

   sleep_ignore_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
      (sleeping_q && sleep_instr && !wake_ev) |=> sleeping_q && $stable(pd_n_q))
      else $error("sleep instruction while asleep had effect");

   sequence edge_wake_s;
      wake_q ##1 !wake_q;
   endsequence

   edge_wake_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R13]
      (sleeping_q && external_edge_interrupt) |=> edge_wake_s)
      else $error("edge interrupt did not wake once");

endmodule : wsw_watchdog_sleep_wake

// file: tb/wsw_watchdog_sleep_wake_bench.sv
`timescale 1ns/1ps

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module wsw_watchdog_sleep_wake_bench;
   import wsw_pkg::*;

   localparam int BT = 2;

   logic            sys_clk;
   logic            nrst;
   wsw_bus_req_type bus_req;
   logic [7:0]      rdata_q;
   logic [7:0]      cfg;
   logic            master_clear_pin_n;
   logic            clr_instr;
   logic            sleep_instr;
   logic            edge_int;
   logic            port_b_change;
   wsw_periph_type  periph;
   logic [7:0]      port_drive;
   logic [7:0]      port_oe_n;
   logic [7:0]      port_out_q;
   logic [7:0]      port_oe_n_q;
   logic            watchdog_reset_q;
   logic            wake_q;
   logic            sleeping_q;
   logic            osc_driver_on_q;
   logic            irq_q;
   int              err_count;
   int              n_tests;
   int              n;
   logic [7:0]      d;

   wsw_watchdog_sleep_wake #(.BASE_TICKS(BT)) dut (
      .sys_clk                 (sys_clk),
      .nrst                    (nrst),
      .bus_req                 (bus_req),
      .rdata_q                 (rdata_q),
      .watchdog_config_byte    (cfg),
      .master_clear_pin_n      (master_clear_pin_n),
      .clear_watchdog_instr    (clr_instr),
      .sleep_instr             (sleep_instr),
      .external_edge_interrupt (edge_int),
      .port_b_change           (port_b_change),
      .periph                  (periph),
      .port_drive              (port_drive),
      .port_oe_n               (port_oe_n),
      .port_out_q              (port_out_q),
      .port_oe_n_q             (port_oe_n_q),
      .watchdog_reset_q        (watchdog_reset_q),
      .wake_q                  (wake_q),
      .sleeping_q              (sleeping_q),
      .osc_driver_on_q         (osc_driver_on_q),
      .irq_q                   (irq_q)
   );

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic cyc(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
   endtask : bus_wr

   task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      bus_req <= '0;
      #1;
      v = rdata_q;
   endtask : bus_rd

   task automatic pulse(input logic is_sleep);
      @(posedge sys_clk);
      if (is_sleep) sleep_instr <= 1'b1;
      else clr_instr <= 1'b1;
      @(posedge sys_clk);
      sleep_instr <= 1'b0;
      clr_instr <= 1'b0;
      #1;
   endtask : pulse

   // counts cycles until either event pulse; bound returned when none came
   task automatic wait_ev(input int bound, output int c);
      c = 0;
      while (c < bound && watchdog_reset_q !== 1'b1 && wake_q !== 1'b1) begin
         @(posedge sys_clk);
         #1;
         c++;
      end
   endtask : wait_ev

   task automatic src(input int i, input logic v);
      @(posedge sys_clk);
      case (i)
         0: master_clear_pin_n <= !v;
         1: edge_int <= v;
         2: port_b_change <= v;
         3: periph.psp_access <= v;
         4: periph.eeprom_write_done <= v;
         5: periph.low_voltage_detect <= v;
         6: periph.capture_interrupt <= v;
         7: periph.sync_serial_start_stop <= v;
         8: periph.sync_serial_slave <= v;
         9: {periph.timer_three_interrupt, periph.timer_three_async} <= {v, v};
         10: {periph.usart_interrupt, periph.usart_sync_slave} <= {v, v};
         default: {periph.adc_done, periph.adc_rc_clock} <= {v, v};
      endcase
   endtask : src

   task automatic end_sim;
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   initial begin
      #400000;
      err_count++;
      end_sim();
   end

   initial begin
      err_count = 0;
      n_tests = 0;
      nrst = 1'b0;
      bus_req = '0;
      cfg = 8'h1e;
      master_clear_pin_n = 1'b1;
      clr_instr = 1'b0;
      sleep_instr = 1'b0;
      edge_int = 1'b0;
      port_b_change = 1'b0;
      periph = '0;
      port_drive = 8'h5a;
      port_oe_n = 8'h0f;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      cyc(4);
      bus_rd(REG_CTRL, d); `CHK(d, CTRL_RESET)
      bus_rd(REG_CAUSE, d); `CHK(d & 8'h18, 8'h18)
      bus_rd(REG_CFG, d); `CHK(d, 8'h1e)
      bus_rd(4'hf, d); `CHK(d, BYTE_ZERO)
      bus_wr(REG_IRQ_CLEAR, 8'h0f);
      bus_wr(REG_CTRL, 8'hff);
      bus_rd(REG_CTRL, d); `CHK(d, 8'h01)
      // software enable off with config enable clear: no timeout at all
      bus_wr(REG_CTRL, 8'h00);
      cfg <= 8'h00;
      wait_ev(1200, n); `CHK(n, 1200)
      bus_wr(REG_CTRL, 8'h01);
      wait_ev(1200, n); `CHK(n <= BT * RC_CYC + 4, 1'b1)
      `CHK(watchdog_reset_q, 1'b1)
      // periodic clears keep the running watchdog quiet
      repeat (12) begin
         pulse(1'b0);
         wait_ev(100, n); `CHK(n, 100)
      end
      bus_wr(REG_CTRL, 8'h00);
      // config enable overrides software off; ratio 2^select
      for (int ps = 0; ps < 3; ps++) begin
         cfg <= {3'b000, 4'(ps), 1'b1};
         cyc(4);
         pulse(1'b0);
         wait_ev(1200, n);
         `CHK(n >= (BT << ps) * RC_CYC - RC_CYC - 2, 1'b1)
         `CHK(n <= (BT << ps) * RC_CYC + 4, 1'b1)
         `CHK(watchdog_reset_q, 1'b1)
      end
      bus_rd(REG_CAUSE, d); `CHK(d & 8'h18, 8'h08)
      bus_rd(REG_IRQ_STATUS, d); `CHK(d & 8'h0f, 8'h09)
      `CHK(irq_q, 1'b0)
      bus_wr(REG_IRQ_ENABLE, 8'h08);
      cyc(3); `CHK(irq_q, 1'b1)
      bus_rd(REG_IRQ_ENABLE, d); `CHK(d, 8'h08)
      bus_wr(REG_IRQ_CLEAR, 8'h0f);
      cyc(3); `CHK(irq_q, 1'b0)
      bus_rd(REG_IRQ_CLEAR, d); `CHK(d, BYTE_ZERO)
      bus_wr(REG_IRQ_ENABLE, 8'h00);
      // sleep with the watchdog forced on: timeout wakes, no reset
      cfg <= 8'h01;
      cyc(4);
      pulse(1'b1);
      `CHK({sleeping_q, osc_driver_on_q}, 2'b10)
      port_drive <= 8'ha5;
      port_oe_n <= 8'hf0;
      bus_rd(REG_CAUSE, d); `CHK(d & 8'h18, 8'h10)
      wait_ev(400, n); `CHK(n <= BT * RC_CYC + 4, 1'b1)
      `CHK({wake_q, watchdog_reset_q}, 2'b10)
      `CHK({port_out_q, port_oe_n_q}, 16'h5a0f)
      cyc(1); `CHK({sleeping_q, osc_driver_on_q}, 2'b01)
      cyc(2); `CHK({port_out_q, port_oe_n_q}, 16'ha5f0)
      bus_rd(REG_CAUSE, d); `CHK(d & 8'h18, 8'h00)
      `CHK(d[CAUSE_TO_BIT], 1'b0)
      bus_rd(REG_IRQ_STATUS, d); `CHK(d & 8'h0f, 8'h07)
      bus_wr(REG_IRQ_CLEAR, 8'h0f);
      // watchdog off; unqualified peripheral lines must not wake
      cfg <= 8'h00;
      cyc(4);
      pulse(1'b1);
      periph.timer_one_interrupt <= 1'b1;
      periph.usart_interrupt <= 1'b1;
      periph.adc_done <= 1'b1;
      periph.timer_three_interrupt <= 1'b1;
      wait_ev(40, n); `CHK(n, 40)
      periph.timer_one_async <= 1'b1;
      wait_ev(8, n); `CHK(wake_q, 1'b1)
      periph <= '0;
      cyc(4);
      for (int i = 0; i < 12; i++) begin
         pulse(1'b1);
         wait_ev(10, n); `CHK(n, 10)
         src(i, 1'b1);
         wait_ev(10, n); `CHK(wake_q, 1'b1)
         src(i, 1'b0);
         cyc(6);
      end
      // reset in mid-run returns software enable and flags to reset state
      bus_wr(REG_CTRL, 8'h01);
      nrst <= 1'b0;
      cyc(2);
      nrst <= 1'b1;
      cyc(4);
      bus_rd(REG_CTRL, d); `CHK(d, CTRL_RESET)
      bus_rd(REG_CAUSE, d); `CHK(d & 8'h18, 8'h18)
      `CHK({sleeping_q, osc_driver_on_q, irq_q}, 3'b010)
      end_sim();
   end

endmodule : wsw_watchdog_sleep_wake_bench
